// ===== rtl/dcr_pkg.sv
// Package with register map, field layout and types of the channel control block.
package dcr_pkg;
   localparam int NUM_CH     = 16;
   localparam int SEL_W      = 4;
   localparam int ADDR_W     = 12;
   localparam int DATA_W     = 32;
   localparam int FIFO_W     = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int REQ_W      = 64;
   localparam int BEATS_W    = 8;

   // Printed offsets are register indices; the byte address is four times the index.
   localparam logic [ADDR_W-1:0] IDX_DESC_BASE = 12'h034;
   localparam logic [ADDR_W-1:0] IDX_WB_BASE   = 12'h038;
   localparam logic [ADDR_W-1:0] IDX_CH_SEL    = 12'h03f;
   localparam logic [ADDR_W-1:0] IDX_CTRL_PRI  = 12'h040;
   localparam logic [ADDR_W-1:0] IDX_CTRL_SEC  = 12'h044;
   localparam logic [ADDR_W-1:0] ADDR_DESC_BASE = IDX_DESC_BASE << 2;
   localparam logic [ADDR_W-1:0] ADDR_WB_BASE   = IDX_WB_BASE << 2;
   localparam logic [ADDR_W-1:0] ADDR_CH_SEL    = IDX_CH_SEL << 2;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_PRI  = IDX_CTRL_PRI << 2;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_SEC  = IDX_CTRL_SEC << 2;

   localparam logic [DATA_W-1:0] RST_BASE = 32'h0000_0000;

   localparam int PRI_RST_BIT = 0;
   localparam int PRI_EN_BIT  = 1;
   localparam int SEC_CMD_LSB = 24;
   localparam int SEC_TA_LSB  = 22;
   localparam int SEC_TS_LSB  = 8;
   localparam int SEC_LVL_LSB = 5;
   localparam int SEC_EVO_BIT = 4;
   localparam int SEC_EVI_BIT = 3;
   localparam int SEC_EVA_LSB = 0;

   localparam logic [1:0] CMD_NONE    = 2'h0;
   localparam logic [1:0] CMD_SUSPEND = 2'h1;
   localparam logic [1:0] CMD_RESUME  = 2'h2;

   localparam logic [1:0] TA_BLOCK = 2'h0;
   localparam logic [1:0] TA_BEAT  = 2'h2;
   localparam logic [1:0] TA_TXN   = 2'h3;

   localparam logic [5:0] TS_SOFTWARE_ONLY = 6'h00;

   localparam logic [BEATS_W-1:0] BLOCK_BEATS = 8'h10;
   localparam logic [BEATS_W-1:0] TXN_BEATS   = 8'h04;
   localparam logic [BEATS_W-1:0] ONE_BEAT    = 8'h01;

   typedef enum logic [1:0] {ENG_IDLE, ENG_BURST, ENG_DRAIN} dcr_eng_t;

   typedef struct packed {
      logic       enable;
      logic       disable_pend;
      logic       rst_busy;
      logic       suspended;
      logic [1:0] trig_action;
      logic [5:0] trig_source;
      logic [1:0] arb_priority;
      logic       ev_out_en;
      logic       ev_in_en;
      logic [2:0] ev_action;
   } dcr_ch_t;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic              ready;
      logic              slverr;
   } dcr_apb_rsp_t;
endpackage

// ===== rtl/dcr_channel_control.sv
// Channel control registers, burst engine and data buffer of the direct memory access block.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dcr_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     clk_en,
   input  wire logic                     in_valid,
   output logic                          in_ready,
   input  wire logic [WIDTH-1:0]         in_data,
   output logic                          out_valid,
   input  wire logic                     out_ready,
   output logic [WIDTH-1:0]              out_data,
   output logic [$clog2(DEPTH+1)-1:0]    count
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH+1);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            rd_ptr;
      logic [PTR_W-1:0]            wr_ptr;
      logic [CNT_W-1:0]            cnt;
      logic                        nonempty;
      logic                        notfull;
   } dcr_fifo_st_t;

   dcr_fifo_st_t s;
   dcr_fifo_st_t next_s;
   logic         push;
   logic         pop;

   function automatic logic [PTR_W-1:0] dcr_wrap(input logic [PTR_W-1:0] p);
      dcr_wrap = (p == LAST_PTR) ? '0 : p + 1'b1;
   endfunction

   assign in_ready  = s.notfull;
   assign out_valid = s.nonempty;
   assign out_data  = s.mem[s.rd_ptr];
   assign count     = s.cnt;
   assign push      = in_valid & s.notfull;
   assign pop       = out_ready & s.nonempty;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr_ptr] = in_data;
         next_s.wr_ptr        = dcr_wrap(s.wr_ptr);
      end
      if (pop) begin
         next_s.rd_ptr = dcr_wrap(s.rd_ptr);
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + 1'b1;
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - 1'b1;
      end
      next_s.nonempty = (next_s.cnt != '0);
      next_s.notfull  = (next_s.cnt != FULL_CNT);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{default: '0, notfull: 1'b1};
      end else if (clk_en) begin
         s <= next_s;
      end
   end
endmodule

module dcr_channel_control
   import dcr_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 clk_en,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [DATA_W-1:0]    pwdata,
   output logic [DATA_W-1:0]         prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 write_lock,
   input  wire logic [REQ_W-1:0]     periph_req,
   input  wire logic                 src_valid,
   input  wire logic [FIFO_W-1:0]    src_data,
   output logic                      src_ready,
   output logic                      dst_valid,
   input  wire logic                 dst_ready,
   output logic [FIFO_W-1:0]         dst_data,
   output logic                      engine_busy,
   output logic [SEL_W-1:0]          active_channel
);
   localparam int CNT_W = $clog2(FIFO_DEPTH+1);
   localparam logic [CNT_W-1:0] ROOM_CNT = CNT_W'(FIFO_DEPTH - 2);

   typedef struct packed {
      dcr_ch_t [NUM_CH-1:0] ch;
      logic [DATA_W-1:0]    desc_base;
      logic [DATA_W-1:0]    wb_base;
      logic [SEL_W-1:0]     sel;
      dcr_eng_t             eng;
      logic [SEL_W-1:0]     act;
      logic [BEATS_W-1:0]   remain;
      logic                 src_ready;
      logic                 busy;
      dcr_apb_rsp_t         rsp;
   } dcr_state_t;

   dcr_state_t       s;
   dcr_state_t       next_s;
   logic             fifo_in_ready;
   logic [CNT_W-1:0] fifo_count;
   logic             accept;

   function automatic logic any_enabled(input dcr_ch_t [NUM_CH-1:0] c);
      any_enabled = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         any_enabled = any_enabled | c[i].enable;
      end
   endfunction

   function automatic logic chan_wants(input dcr_ch_t c, input logic [REQ_W-1:0] req);
      chan_wants = c.enable && !c.disable_pend && !c.suspended && !c.rst_busy &&
                   (c.trig_source != TS_SOFTWARE_ONLY) && req[c.trig_source];
   endfunction

   function automatic logic [BEATS_W-1:0] burst_beats(input logic [1:0] ta);
      unique case (ta)
         TA_BEAT: burst_beats = ONE_BEAT;
         TA_TXN:  burst_beats = TXN_BEATS;
         default: burst_beats = BLOCK_BEATS;
      endcase
   endfunction

   function automatic logic guarded(input logic [ADDR_W-1:0] a);
      guarded = (a == ADDR_DESC_BASE) || (a == ADDR_WB_BASE) ||
                (a == ADDR_CTRL_PRI) || (a == ADDR_CTRL_SEC);
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = guarded(a) || (a == ADDR_CH_SEL);
   endfunction

   function automatic logic [DATA_W-1:0] read_word(input dcr_state_t st,
                                                   input logic [ADDR_W-1:0] a);
      dcr_ch_t c;
      c         = st.ch[st.sel];
      read_word = '0;
      if (a == ADDR_DESC_BASE) begin
         read_word = st.desc_base;
      end else if (a == ADDR_WB_BASE) begin
         read_word = st.wb_base;
      end else if (a == ADDR_CH_SEL) begin
         read_word[SEL_W-1:0] = st.sel;
      end else if (a == ADDR_CTRL_PRI) begin
         read_word[PRI_EN_BIT]  = c.enable;
         read_word[PRI_RST_BIT] = c.rst_busy;
      end else if (a == ADDR_CTRL_SEC) begin
         read_word[SEC_TA_LSB +: 2]  = c.trig_action;
         read_word[SEC_TS_LSB +: 6]  = c.trig_source;
         read_word[SEC_LVL_LSB +: 2] = c.arb_priority;
         read_word[SEC_EVO_BIT]      = c.ev_out_en;
         read_word[SEC_EVI_BIT]      = c.ev_in_en;
         read_word[SEC_EVA_LSB +: 3] = c.ev_action;
      end
   endfunction

   assign prdata         = s.rsp.rdata;
   assign pready         = s.rsp.ready;
   assign pslverr        = s.rsp.slverr;
   assign src_ready      = s.src_ready;
   assign engine_busy    = s.busy;
   assign active_channel = s.act;
   assign accept         = src_valid & s.src_ready & fifo_in_ready;

   dcr_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .clk_en    (clk_en),
      .in_valid  (accept),
      .in_ready  (fifo_in_ready),
      .in_data   (src_data),
      .out_valid (dst_valid),
      .out_ready (dst_ready),
      .out_data  (dst_data),
      .count     (fifo_count)
   );

   always_comb begin
      logic       wr;
      logic       wr_ok;
      logic       found;
      logic [1:0] best_lvl;
      logic [SEL_W-1:0] best;
      dcr_ch_t    c;
      wr       = 1'b0;
      wr_ok    = 1'b0;
      found    = 1'b0;
      best_lvl = '0;
      best     = '0;
      c        = '0;
      next_s   = s;

      // APB: setup cycle prepares a registered answer, access cycle completes.
      next_s.rsp.ready  = psel && !penable;
      next_s.rsp.rdata  = '0;
      next_s.rsp.slverr = 1'b0;
      if (psel && !penable) begin
         next_s.rsp.rdata  = pwrite ? '0 : read_word(s, paddr);
         next_s.rsp.slverr = !mapped(paddr) || (pwrite && write_lock && guarded(paddr));
      end
      wr    = psel && penable && s.rsp.ready && pwrite;
      wr_ok = wr && !s.rsp.slverr;

      // Soft reset finishes one cycle after it starts.
      for (int i = 0; i < NUM_CH; i++) begin
         if (s.ch[i].rst_busy) begin
            next_s.ch[i] = '0;
         end else if (s.ch[i].disable_pend && !(s.eng != ENG_IDLE && s.act == SEL_W'(i))) begin
            next_s.ch[i].enable       = 1'b0;
            next_s.ch[i].disable_pend = 1'b0;
         end
      end

      // Burst engine.
      unique case (s.eng)
         ENG_IDLE: begin
            for (int i = 0; i < NUM_CH; i++) begin
               if (chan_wants(s.ch[i], periph_req) &&
                   (!found || s.ch[i].arb_priority > best_lvl)) begin
                  found    = 1'b1;
                  best_lvl = s.ch[i].arb_priority;
                  best     = SEL_W'(i);
               end
            end
            if (found) begin
               next_s.eng    = ENG_BURST;
               next_s.act    = best;
               next_s.remain = burst_beats(s.ch[best].trig_action);
            end
         end
         ENG_BURST: begin
            if (accept) begin
               next_s.remain = s.remain - 1'b1;
            end
            if (next_s.remain == '0) begin
               next_s.eng = ENG_DRAIN;
            end
         end
         ENG_DRAIN: begin
            if (fifo_count == '0) begin
               next_s.eng = ENG_IDLE;
            end
         end
      endcase
      next_s.busy      = (next_s.eng != ENG_IDLE);
      next_s.src_ready = (next_s.eng == ENG_BURST) && (next_s.remain != '0) &&
                         (fifo_count <= ROOM_CNT);

      // Register writes.
      c = s.ch[s.sel];
      if (wr_ok && paddr == ADDR_DESC_BASE && !any_enabled(s.ch)) begin
         next_s.desc_base = pwdata;
      end
      if (wr_ok && paddr == ADDR_WB_BASE && !any_enabled(s.ch)) begin
         next_s.wb_base = pwdata;
      end
      if (wr_ok && paddr == ADDR_CH_SEL) begin
         next_s.sel = pwdata[SEL_W-1:0];
      end
      if (wr_ok && paddr == ADDR_CTRL_PRI && !c.rst_busy) begin
         if (pwdata[PRI_RST_BIT]) begin
            if (!c.enable) begin
               next_s.ch[s.sel].rst_busy = 1'b1;
            end
         end else if (pwdata[PRI_EN_BIT]) begin
            next_s.ch[s.sel].enable       = 1'b1;
            next_s.ch[s.sel].disable_pend = 1'b0;
         end else if (c.enable) begin
            next_s.ch[s.sel].disable_pend = 1'b1;
         end
      end
      if (wr_ok && paddr == ADDR_CTRL_SEC && !c.rst_busy) begin
         next_s.ch[s.sel].arb_priority = pwdata[SEC_LVL_LSB +: 2];
         if (pwdata[SEC_CMD_LSB +: 2] == CMD_SUSPEND) begin
            next_s.ch[s.sel].suspended = 1'b1;
         end else if (pwdata[SEC_CMD_LSB +: 2] == CMD_RESUME) begin
            next_s.ch[s.sel].suspended = 1'b0;
         end
         if (!c.enable) begin
            next_s.ch[s.sel].trig_action = pwdata[SEC_TA_LSB +: 2];
            next_s.ch[s.sel].trig_source = pwdata[SEC_TS_LSB +: 6];
            next_s.ch[s.sel].ev_out_en   = pwdata[SEC_EVO_BIT];
            next_s.ch[s.sel].ev_in_en    = pwdata[SEC_EVI_BIT];
            next_s.ch[s.sel].ev_action   = pwdata[SEC_EVA_LSB +: 3];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{default: '0, desc_base: RST_BASE, wb_base: RST_BASE, eng: ENG_IDLE};
      end else if (clk_en) begin
         s <= next_s;
      end
   end
endmodule

`default_nettype wire

// ===== sim/dcr_cc_assertions.sv
// Port-level assertion checker for the channel control block.
`timescale 1ns/1ps
`default_nettype none
module dcr_cc_checker
   import dcr_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              clk_en,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              write_lock,
   input wire logic              src_valid,
   input wire logic              src_ready,
   input wire logic              dst_valid,
   input wire logic              dst_ready,
   input wire logic [FIFO_W-1:0] dst_data,
   input wire logic              engine_busy
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       mapped;
   logic [7:0] beats;
   assign mapped = paddr inside {ADDR_DESC_BASE, ADDR_WB_BASE, ADDR_CH_SEL, ADDR_CTRL_PRI,
                                 ADDR_CTRL_SEC};
   // Counts source beats of the burst in progress.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         beats <= 8'h00;
      end else if (!engine_busy) begin
         beats <= 8'h00;
      end else if (src_valid && src_ready && clk_en) begin
         beats <= beats + 8'h01;
      end
   end
   sequence setup_s;
      psel && !penable && clk_en;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence
   ready_after_setup_a: assert property (setup_s |=> answer_s)
      else $error("pready not a single cycle after setup");
   ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable))
      else $error("pready rose without setup");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("prdata not zero outside an answer");
   unmapped_err_a: assert property (setup_s ##0 !mapped |=> pslverr)
      else $error("unmapped access without error");
   lock_err_a: assert property (setup_s ##0 (pwrite && write_lock && paddr == ADDR_DESC_BASE)
      |=> pslverr)
      else $error("locked write without error");
   busy_fall_a: assert property ($fell(engine_busy) |-> !$past(dst_valid))
      else $error("engine idle with buffer not empty");
   burst_len_a: assert property ($fell(engine_busy) |-> beats inside {8'h01, 8'h04, 8'h10})
      else $error("burst length wrong");
   src_gate_a: assert property (src_ready |-> engine_busy)
      else $error("source ready while engine idle");
   dst_hold_a: assert property (dst_valid && !dst_ready && clk_en |=> dst_valid && $stable(dst_data))
      else $error("buffer output changed while stalled");
endmodule
bind dcr_channel_control dcr_cc_checker i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .write_lock(write_lock), .src_valid(src_valid),
   .src_ready(src_ready), .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data),
   .engine_busy(engine_busy));
`default_nettype wire

// ===== sim/dcr_stream_partner.sv
// Stream source and sink on the far side of the data buffer.
`timescale 1ns/1ps
`default_nettype none
module dcr_stream_partner
   import dcr_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              stall,
   output logic                   src_valid,
   input  wire logic              src_ready,
   output logic [FIFO_W-1:0]      src_data,
   input  wire logic              dst_valid,
   output logic                   dst_ready,
   input  wire logic [FIFO_W-1:0] dst_data,
   output logic [31:0]            rx_count,
   output logic [7:0]             rx_err
);
   // Words count up from zero so the sink can check order against its own count.
   assign src_valid = presetn;
   assign dst_ready = !stall;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_data <= 32'h0000_0000;
         rx_count <= 32'h0000_0000;
         rx_err   <= 8'h00;
      end else begin
         if (src_valid && src_ready) begin
            src_data <= src_data + 32'h0000_0001;
         end
         if (dst_valid && dst_ready) begin
            rx_count <= rx_count + 32'h0000_0001;
            if (dst_data !== rx_count) begin
               rx_err <= rx_err + 8'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/tb_dcr_channel_control.sv
// Self-checking testbench of the channel control block.
`timescale 1ns/1ps
`default_nettype none
module tb_dcr_channel_control import dcr_pkg::*;;
   logic              pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic              write_lock, src_valid, src_ready, dst_valid, dst_ready, engine_busy, stall;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rx_count, n0;
   logic [REQ_W-1:0]  periph_req;
   logic [FIFO_W-1:0] src_data, dst_data;
   logic [SEL_W-1:0]  active_channel;
   logic [7:0]        rx_err;
   int                errors, checks, i;
   dcr_channel_control i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .write_lock(write_lock), .periph_req(periph_req),
      .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
      .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data),
      .engine_busy(engine_busy), .active_channel(active_channel));
   dcr_stream_partner i_far (.pclk(pclk), .presetn(presetn), .stall(stall),
      .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
      .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data),
      .rx_count(rx_count), .rx_err(rx_err));
   always #12.5 pclk = ~pclk;
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic [DATA_W-1:0] exp, input logic err);
      int n;
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      // The access phase lasts until pready is seen high; only the watchdog ends a hung wait.
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1);
      if (!w) begin
         chk("prdata", exp, prdata);
      end
      chk("pready pslverr", {30'h0, 1'h1, err}, {30'h0, pready, pslverr});
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task wbusy(input logic v);
      int n;
      for (n = 0; n < 400 && engine_busy !== v; n++) @(posedge pclk);
      chk("engine_busy", {31'h0, v}, {31'h0, engine_busy});
   endtask
   task xfer(input logic [1:0] ta);
      logic [31:0] start;
      start = rx_count;
      acc(1'h1, ADDR_CTRL_SEC, {8'h00, ta, 22'h000100}, '0, 1'h0);
      acc(1'h1, ADDR_CTRL_PRI, 32'h2, '0, 1'h0);
      periph_req[1] <= 1'h1;
      wbusy(1'h1);
      periph_req[1] <= 1'h0;
      wbusy(1'h0);
      chk("active_channel", 32'h3, {28'h0, active_channel});
      acc(1'h1, ADDR_CTRL_PRI, '0, '0, 1'h0);
      chk("beats", (ta == 2'h2) ? 1 : (ta == 2'h3) ? 4 : 16, rx_count - start);
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // The tests need a few hundred cycles; the watchdog allows twenty thousand.
   initial begin
      #500000;
      errors++;
      $display("[ERR] watchdog expected finish seen timeout");
      end_of_test;
   end
   initial begin
      pclk = 1'h0;
      presetn = 1'h0;
      clk_en = 1'h1;
      {psel, penable, pwrite, write_lock, stall} = '0;
      paddr = '0;
      pwdata = '0;
      periph_req = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      acc(1'h0, ADDR_DESC_BASE, '0, RST_BASE, 1'h0);
      acc(1'h0, ADDR_WB_BASE, '0, RST_BASE, 1'h0);
      acc(1'h0, ADDR_CH_SEL, '0, '0, 1'h0);
      acc(1'h0, ADDR_CTRL_PRI, '0, '0, 1'h0);
      acc(1'h0, ADDR_CTRL_SEC, '0, '0, 1'h0);
      acc(1'h0, 12'h004, '0, '0, 1'h1);
      write_lock <= 1'h1;
      acc(1'h1, ADDR_DESC_BASE, 32'h1234_5670, '0, 1'h1);
      write_lock <= 1'h0;
      acc(1'h0, ADDR_DESC_BASE, '0, '0, 1'h0);
      acc(1'h1, ADDR_DESC_BASE, 32'h1234_5670, '0, 1'h0);
      acc(1'h1, ADDR_WB_BASE, 32'hcafe_0000, '0, 1'h0);
      acc(1'h0, ADDR_DESC_BASE, '0, 32'h1234_5670, 1'h0);
      acc(1'h0, ADDR_WB_BASE, '0, 32'hcafe_0000, 1'h0);
      acc(1'h1, ADDR_CH_SEL, 32'hffff_fff3, '0, 1'h0);
      acc(1'h0, ADDR_CH_SEL, '0, 32'h3, 1'h0);
      for (i = 0; i < 4; i++) xfer(i[1:0]);
      acc(1'h1, ADDR_CTRL_SEC, 32'h0000_0100, '0, 1'h0);
      acc(1'h1, ADDR_CTRL_PRI, 32'h2, '0, 1'h0);
      acc(1'h1, ADDR_DESC_BASE, '0, '0, 1'h0);
      acc(1'h0, ADDR_DESC_BASE, '0, 32'h1234_5670, 1'h0);
      stall <= 1'h1;
      periph_req[1] <= 1'h1;
      wbusy(1'h1);
      periph_req[1] <= 1'h0;
      n0 = rx_count;
      repeat (30) @(posedge pclk);
      chk("src_ready", '0, {31'h0, src_ready});
      acc(1'h1, ADDR_CTRL_PRI, 32'h1, '0, 1'h0);
      acc(1'h1, ADDR_CTRL_PRI, '0, '0, 1'h0);
      acc(1'h0, ADDR_CTRL_PRI, '0, 32'h2, 1'h0);
      stall <= 1'h0;
      wbusy(1'h0);
      acc(1'h0, ADDR_CTRL_PRI, '0, '0, 1'h0);
      chk("beats", 32'h10, rx_count - n0);
      acc(1'h0, ADDR_CTRL_SEC, '0, 32'h0000_0100, 1'h0);
      acc(1'h1, ADDR_CTRL_SEC, 32'h0080_0100, '0, 1'h0);
      acc(1'h1, ADDR_CTRL_PRI, 32'h2, '0, 1'h0);
      acc(1'h1, ADDR_CTRL_SEC, 32'h0100_0060, '0, 1'h0);
      acc(1'h0, ADDR_CTRL_SEC, '0, 32'h0080_0160, 1'h0);
      periph_req[1] <= 1'h1;
      acc(1'h1, ADDR_CTRL_SEC, 32'h0300_0060, '0, 1'h0);
      repeat (20) @(posedge pclk);
      chk("engine_busy", '0, {31'h0, engine_busy});
      acc(1'h1, ADDR_CTRL_SEC, 32'h0200_0060, '0, 1'h0);
      wbusy(1'h1);
      periph_req[1] <= 1'h0;
      wbusy(1'h0);
      acc(1'h1, ADDR_CTRL_PRI, '0, '0, 1'h0);
      acc(1'h0, ADDR_CTRL_PRI, '0, '0, 1'h0);
      acc(1'h0, ADDR_CTRL_SEC, '0, 32'h0080_0160, 1'h0);
      acc(1'h1, ADDR_CH_SEL, 32'h5, '0, 1'h0);
      acc(1'h0, ADDR_CTRL_SEC, '0, '0, 1'h0);
      acc(1'h1, ADDR_CH_SEL, 32'h3, '0, 1'h0);
      acc(1'h1, ADDR_CTRL_PRI, 32'h1, '0, 1'h0);
      acc(1'h0, ADDR_CTRL_PRI, '0, '0, 1'h0);
      acc(1'h0, ADDR_CTRL_SEC, '0, '0, 1'h0);
      chk("order", '0, {24'h0, rx_err});
      end_of_test;
   end
endmodule
`default_nettype wire
